// *** verilog/cmh_pkg.sv ***
package cmh_pkg;
    // register byte offsets (own map over the plain register port)
    localparam logic [7:0] ADDR_PEAK     = 8'h00; // ovld[7:6] en[5:4] per[1:0]
    localparam logic [7:0] ADDR_OVLD_PCT = 8'h04; // code in [7:3]
    localparam logic [7:0] ADDR_MODE     = 8'h08; // mode control bits
    localparam logic [7:0] ADDR_HOT_EN   = 8'h0C; // event enables [7:0]
    localparam logic [7:0] ADDR_HOT_CFG  = 8'h10; // ext[6] width[5:4] latch[3]
    localparam logic [7:0] ADDR_HOT_STAT = 8'h14; // nine status bits
    localparam logic [7:0] ADDR_LIMITS   = 8'h18; // prog limit / effective
    localparam logic [7:0] ADDR_STATE    = 8'h1C; // live state, read only

    // mode register bit positions
    localparam int B_LEARN     = 0;
    localparam int B_SHIP      = 1;
    localparam int B_PASS      = 2;
    localparam int B_LATCHOFF  = 3;
    localparam int B_SUP_DIS   = 4;
    localparam int B_REV_EN    = 5;
    localparam int B_OPT_EN    = 6;
    localparam int B_EXT_EN    = 7;
    localparam int B_PIN_PASS  = 8;
    localparam int B_LOWPWR    = 9;
    localparam int B_CMP_SYS   = 10;
    localparam int MODE_W      = 11;
    localparam logic [MODE_W-1:0] MODE_RST = 11'h090; // disable + ext pin

    // hot config fields
    localparam int HC_EXT   = 6;
    localparam int HC_WHI   = 5;
    localparam int HC_WLO   = 4;
    localparam int HC_LATCH = 3;
    localparam logic [7:0] HOT_CFG_RST = 8'h10;

    // event indexes (status bit order); bit 8 is support exit
    localparam int EV_INPUT_VOLTAGE_REGULATION_EVENT = 7;
    localparam int EV_EXIT   = 8;
    localparam int NEV       = 9;

    // overload percentage coding
    localparam logic [8:0] PCT_BASE  = 9'h06E; // 110
    localparam logic [8:0] PCT_STEP  = 9'h005;
    localparam logic [8:0] PCT_BASE2 = 9'h0FA; // 250
    localparam logic [8:0] PCT_STEP2 = 9'h032;
    localparam logic [4:0] PCT_SPLIT = 5'h19;  // first 50% step code
    localparam logic [4:0] PCT_TOP   = 5'h1D;  // 450 and above clamp

    // timing in milliseconds; 10 MHz clock
    localparam int CLK_HZ      = 10_000_000;
    localparam int MS_CYC      = CLK_HZ / 1000;
    localparam int SHIP_MS     = 120;
    localparam int SHIP_CYC    = SHIP_MS * MS_CYC;
    localparam int OVLD_MS0    = 1;   // overload duration per code, ms
    localparam int PER_MS0     = 1;   // peak period per code, ms
    localparam int HOT_W_MS0   = 10;  // pulse width base, ms
    localparam int CNT_W       = 24;
endpackage : cmh_pkg

// *** verilog/cmh_ctrl.sv ***
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
module cmh_ctrl #(
    parameter int SHIP_CYCLES = cmh_pkg::SHIP_CYC,
    parameter int MS_CYCLES   = cmh_pkg::MS_CYC
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [7:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    input  wire logic        batt_discharging,
    input  wire logic        sys_droop,
    input  wire logic        at_dc_limit,
    input  wire logic        load_high,
    input  wire logic        reverse_support_pin,
    input  wire logic        limit_highz_pin,
    input  wire logic        battery_present_pin,
    input  wire logic        adapter_present_flag,
    input  wire logic        comparator_output,
    input  wire logic        input_overvoltage,
    input  wire logic        system_overvoltage,
    input  wire logic        thermal_shutdown,
    input  wire logic        battery_overcurrent,
    input  wire logic        input_overcurrent,
    input  wire logic        peak_over_limit,
    input  wire logic        avg_over_limit,
    input  wire logic        discharge_over_limit,
    input  wire logic        sys_below_alert_level,
    input  wire logic        input_voltage_low,
    input  wire logic [7:0]  optimizer_limit,
    output logic             overload_active,
    output logic [8:0]       overload_pct,
    output logic             min_voltage_support,
    output logic             processor_hot_alert_n,
    output logic             pass_through,
    output logic             high_sides_on,
    output logic             converter_off,
    output logic             charge_good_output,
    output logic             ship_discharge,
    output logic             battery_switch_on
);
    logic [7:0]          peak_r;
    logic [4:0]          pct_code_r;
    logic [cmh_pkg::MODE_W-1:0] mode_r;
    logic [7:0]          hot_en_r;
    logic [7:0]          hot_cfg_r;
    logic [8:0]          stat_r;
    logic [7:0]          prog_lim_r;
    logic [7:0]          eff_lim_r;
    logic                support_r;
    logic                latched_r;
    logic                cmp_d_r;
    logic                bat_d_r;
    logic                ac_d_r;
    logic                sup_d_r;
    logic                fault_latched_r;
    logic                peak_on_r;
    logic [cmh_pkg::CNT_W-1:0] peak_cnt_r;
    logic [cmh_pkg::CNT_W-1:0] hot_cnt_r;
    logic [cmh_pkg::CNT_W-1:0] ship_cnt_r;
    logic                hot_r;
    logic                hold_r;

    // overload code to percent
    function automatic logic [8:0] pct_of(input logic [4:0] c);
        logic [4:0] k;
        k = (c > cmh_pkg::PCT_TOP) ? cmh_pkg::PCT_TOP : c;
        if (k < cmh_pkg::PCT_SPLIT) begin
            pct_of = cmh_pkg::PCT_BASE + 9'(k) * cmh_pkg::PCT_STEP;
        end else begin
            pct_of = cmh_pkg::PCT_BASE2
                   + 9'(k - cmh_pkg::PCT_SPLIT) * cmh_pkg::PCT_STEP2;
        end
    endfunction : pct_of

    // ms code (0..3) to cycle count
    function automatic logic [cmh_pkg::CNT_W-1:0] ms_cyc(
        input logic [1:0] c, input int base);
        ms_cyc = cmh_pkg::CNT_W'((int'(c) + 1) * base * MS_CYCLES);
    endfunction : ms_cyc

    wire wr_mode   = wr && addr == cmh_pkg::ADDR_MODE;
    wire wr_hotcfg = wr && addr == cmh_pkg::ADDR_HOT_CFG;
    wire rd_stat   = rd && addr == cmh_pkg::ADDR_HOT_STAT;

    wire any_fault = input_overvoltage | system_overvoltage
                   | thermal_shutdown | battery_overcurrent;
    wire cmp_fall  = cmp_d_r & ~comparator_output;
    wire force_lo  = mode_r[cmh_pkg::B_LATCHOFF] & cmp_fall;
    wire bat_gone  = bat_d_r & ~battery_present_pin;
    // low power watch bypasses the enables, which the host leaves at zero
    wire lp_cmp    = mode_r[cmh_pkg::B_LOWPWR] & mode_r[cmh_pkg::B_CMP_SYS]
                   & ~comparator_output;

    // raw events, bit order matches status layout
    logic [cmh_pkg::NEV-1:0] ev;
    always_comb begin
        ev    = '0;
        ev[0] = peak_over_limit;
        ev[1] = avg_over_limit;
        ev[2] = discharge_over_limit;
        ev[3] = sys_below_alert_level;
        ev[4] = ac_d_r & ~adapter_present_flag;
        ev[5] = bat_gone;
        ev[6] = cmp_fall | lp_cmp;
        ev[cmh_pkg::EV_INPUT_VOLTAGE_REGULATION_EVENT] = input_voltage_low;
        ev[cmh_pkg::EV_EXIT]   = sup_d_r & ~support_r;
    end
    wire [cmh_pkg::NEV-1:0] ev_en = (ev & {1'b1, hot_en_r})
                                  | {2'b00, lp_cmp, 6'h00};
    wire trig = |ev_en;

    // registers written by the host
    always_ff @(posedge mclk) begin
        if (rst) begin
            peak_r     <= '0;
            pct_code_r <= '0;
            hot_en_r   <= '0;
            prog_lim_r <= '0;
        end else if (wr) begin
            unique case (addr)
                cmh_pkg::ADDR_PEAK:     peak_r     <= wdata[7:0];
                cmh_pkg::ADDR_OVLD_PCT: pct_code_r <= wdata[7:3];
                cmh_pkg::ADDR_HOT_EN:   hot_en_r   <= wdata[7:0];
                cmh_pkg::ADDR_LIMITS:   prog_lim_r <= wdata[7:0];
                default: ;
            endcase
        end
    end

    // mode bits with hardware sets and clears; hardware wins over host write
    always_ff @(posedge mclk) begin
        if (rst) begin
            mode_r <= cmh_pkg::MODE_RST;
        end else begin
            if (wr_mode) mode_r <= wdata[cmh_pkg::MODE_W-1:0];
            if (any_fault | force_lo)
                mode_r[cmh_pkg::B_SUP_DIS] <= 1'b1;
            if (any_fault | input_overcurrent | force_lo)
                mode_r[cmh_pkg::B_PASS] <= 1'b0;
            if (ship_cnt_r == cmh_pkg::CNT_W'(1))
                mode_r[cmh_pkg::B_SHIP] <= 1'b0;
            if (bat_gone)
                mode_r[cmh_pkg::B_LEARN] <= 1'b0;
        end
    end

    // edge history
    always_ff @(posedge mclk) begin
        if (rst) begin
            cmp_d_r <= 1'b1;
            bat_d_r <= 1'b1;
            ac_d_r  <= 1'b1;
            sup_d_r <= 1'b0;
        end else begin
            cmp_d_r <= comparator_output;
            bat_d_r <= battery_present_pin;
            ac_d_r  <= adapter_present_flag;
            sup_d_r <= support_r;
        end
    end

    // support mode entry and exit
    always_ff @(posedge mclk) begin
        if (rst) begin
            support_r <= 1'b0;
        end else begin
            support_r <= ~mode_r[cmh_pkg::B_SUP_DIS]
                       & ~mode_r[cmh_pkg::B_REV_EN]
                       & reverse_support_pin;
        end
    end

    // forced latch-off, held until host clears the enable
    always_ff @(posedge mclk) begin
        if (rst) begin
            fault_latched_r <= 1'b0;
        end else if (force_lo) begin
            fault_latched_r <= 1'b1;
        end else if (!mode_r[cmh_pkg::B_LATCHOFF]) begin
            fault_latched_r <= 1'b0;
        end
    end

    // peak power cycle: overload then relax
    wire [cmh_pkg::CNT_W-1:0] t_ovld =
        ms_cyc(peak_r[7:6], cmh_pkg::OVLD_MS0);
    wire [cmh_pkg::CNT_W-1:0] t_per  =
        ms_cyc(peak_r[1:0], cmh_pkg::PER_MS0);
    wire peak_en = |peak_r[5:4];
    always_ff @(posedge mclk) begin
        if (rst) begin
            peak_on_r  <= 1'b0;
            peak_cnt_r <= '0;
        end else if (!peak_en) begin
            peak_on_r  <= 1'b0;
            peak_cnt_r <= '0;
        end else if (!peak_on_r) begin
            if ((batt_discharging | sys_droop) & at_dc_limit) begin
                peak_on_r  <= 1'b1;
                peak_cnt_r <= '0;
            end
        end else if (peak_cnt_r + 1'b1 >= t_per) begin
            peak_cnt_r <= '0;
            peak_on_r  <= load_high;
        end else begin
            peak_cnt_r <= peak_cnt_r + 1'b1;
        end
    end
    // equal duration and period leaves overload on all cycle
    wire ovld_now = peak_on_r & (peak_cnt_r < t_ovld || t_ovld >= t_per);

    // alert pulse, extension and host latch
    always_ff @(posedge mclk) begin
        if (rst) begin
            hot_r     <= 1'b0;
            hot_cnt_r <= '0;
        end else if (trig & ~hot_r) begin
            hot_r     <= 1'b1;
            hot_cnt_r <= ms_cyc(hot_cfg_r[cmh_pkg::HC_WHI:cmh_pkg::HC_WLO],
                                cmh_pkg::HOT_W_MS0);
        end else if (hot_cnt_r != '0) begin
            hot_cnt_r <= hot_cnt_r - 1'b1;
        end else begin
            hot_r <= trig;
        end
    end

    // sticky hold for extension or regulation/exit events
    wire hold_set = (trig & hot_cfg_r[cmh_pkg::HC_EXT])
                  | ev_en[cmh_pkg::EV_INPUT_VOLTAGE_REGULATION_EVENT]
                  | ev_en[cmh_pkg::EV_EXIT];
    always_ff @(posedge mclk) begin
        if (rst) begin
            hold_r    <= 1'b0;
            hot_cfg_r <= cmh_pkg::HOT_CFG_RST;
        end else begin
            if (wr_hotcfg) hot_cfg_r <= wdata[7:0];
            if (hold_set) begin
                hold_r <= 1'b1;
                hot_cfg_r[cmh_pkg::HC_LATCH] <= 1'b1;
            end else if (wr_hotcfg & ~wdata[cmh_pkg::HC_LATCH]) begin
                hold_r <= 1'b0;
            end
        end
    end

    // status: set wins; read clears only bits whose event is gone
    always_ff @(posedge mclk) begin
        if (rst) begin
            stat_r <= '0;
        end else if (rd_stat) begin
            stat_r <= (stat_r & ev) | ev_en;
        end else begin
            stat_r <= stat_r | ev_en;
        end
    end

    // effective limit report
    always_ff @(posedge mclk) begin
        if (rst) begin
            eff_lim_r <= '0;
        end else begin
            eff_lim_r <= mode_r[cmh_pkg::B_OPT_EN] ?
                         optimizer_limit : prog_lim_r;
        end
    end

    // ship mode discharge timer
    always_ff @(posedge mclk) begin
        if (rst) begin
            ship_cnt_r <= '0;
        end else if (!mode_r[cmh_pkg::B_SHIP]) begin
            ship_cnt_r <= '0;
        end else if (ship_cnt_r == '0 && !ship_discharge) begin
            ship_cnt_r <= cmh_pkg::CNT_W'(SHIP_CYCLES);
        end else if (ship_cnt_r != '0) begin
            ship_cnt_r <= ship_cnt_r - 1'b1;
        end
    end

    wire pt_req = mode_r[cmh_pkg::B_PASS] & mode_r[cmh_pkg::B_PIN_PASS]
                & ~mode_r[cmh_pkg::B_EXT_EN] & ~limit_highz_pin;
    wire learn  = mode_r[cmh_pkg::B_LEARN] & battery_present_pin;

    // registered outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            overload_active       <= 1'b0;
            overload_pct          <= cmh_pkg::PCT_BASE;
            min_voltage_support   <= 1'b0;
            processor_hot_alert_n <= 1'b1;
            pass_through          <= 1'b0;
            high_sides_on         <= 1'b0;
            converter_off         <= 1'b0;
            charge_good_output    <= 1'b1;
            ship_discharge        <= 1'b0;
            battery_switch_on     <= 1'b0;
        end else begin
            overload_active       <= ovld_now;
            overload_pct          <= pct_of(pct_code_r);
            min_voltage_support   <= support_r;
            processor_hot_alert_n <= ~(hot_r | hold_r);
            pass_through          <= pt_req & ~fault_latched_r;
            high_sides_on         <= pt_req & ~fault_latched_r;
            converter_off         <= fault_latched_r | learn;
            charge_good_output    <= ~fault_latched_r;
            ship_discharge        <= ship_cnt_r != '0;
            battery_switch_on     <= learn;
        end
    end

    // read port, data one cycle after strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata <= '0;
        end else if (rd) begin
            unique case (addr)
                cmh_pkg::ADDR_PEAK:     rdata <= {8'h00, peak_r};
                cmh_pkg::ADDR_OVLD_PCT: rdata <= {8'h00, pct_code_r, 3'h0};
                cmh_pkg::ADDR_MODE:     rdata <= 16'(mode_r);
                cmh_pkg::ADDR_HOT_EN:   rdata <= {8'h00, hot_en_r};
                cmh_pkg::ADDR_HOT_CFG:  rdata <= {8'h00, hot_cfg_r};
                cmh_pkg::ADDR_HOT_STAT: rdata <= 16'(stat_r);
                cmh_pkg::ADDR_LIMITS:   rdata <= {eff_lim_r, prog_lim_r};
                cmh_pkg::ADDR_STATE:    rdata <= {12'h000, support_r,
                                          fault_latched_r, hold_r, peak_on_r};
                default:                rdata <= '0;
            endcase
        end else begin
            rdata <= '0;
        end
    end
endmodule : cmh_ctrl

// *** tb/cmh_ctrl_props.sv ***
`timescale 1ns/1ps
module cmh_ctrl_props #(
    parameter int SHIP_CYCLES = 20,
    parameter int MS_CYCLES   = 4
) (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        reverse_support_pin,
    input wire logic        input_overvoltage,
    input wire logic        input_overcurrent,
    input wire logic [8:0]  overload_pct,
    input wire logic        min_voltage_support,
    input wire logic        processor_hot_alert_n,
    input wire logic        pass_through,
    input wire logic        converter_off,
    input wire logic        ship_discharge,
    input wire logic        battery_switch_on
);
    int ship_cnt_r;
    int lo_cnt_r;
    always_ff @(posedge mclk) begin
        if (rst || !ship_discharge) ship_cnt_r <= 0;
        else ship_cnt_r <= ship_cnt_r + 1;
    end
    always_ff @(posedge mclk) begin
        if (rst || processor_hot_alert_n) lo_cnt_r <= 0;
        else lo_cnt_r <= lo_cnt_r + 1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // read data only in the cycle after a read strobe
    property p_rd_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
    property p_pct_rng;
        overload_pct >= 9'h06E && overload_pct <= 9'h1C2;
    endproperty
    a_pct_rng: assert property (p_pct_rng) else $error("pct out of range");
    property p_sup_pin;
        !reverse_support_pin |-> ##[1:3] !min_voltage_support;
    endproperty
    a_sup_pin: assert property (p_sup_pin) else $error("support kept");
    property p_sup_flt;
        input_overvoltage |-> ##[1:3] !min_voltage_support;
    endproperty
    a_sup_flt: assert property (p_sup_flt) else $error("support on fault");
    property p_pass_flt; input_overcurrent |-> ##[1:3] !pass_through; endproperty
    a_pass_flt: assert property (p_pass_flt) else $error("pass on fault");
    property p_learn; battery_switch_on |-> converter_off; endproperty
    a_learn: assert property (p_learn) else $error("switch on, conv on");
    property p_ship_len;
        $fell(ship_discharge) |-> ship_cnt_r == SHIP_CYCLES;
    endproperty
    a_ship_len: assert property (p_ship_len) else $error("ship length");
    property p_hot_min;
        $rose(processor_hot_alert_n) |-> lo_cnt_r >= 10 * MS_CYCLES;
    endproperty
    a_hot_min: assert property (p_hot_min) else $error("alert too short");
endmodule : cmh_ctrl_props

bind cmh_ctrl cmh_ctrl_props #(
    .SHIP_CYCLES(SHIP_CYCLES), .MS_CYCLES(MS_CYCLES)
) u_props (
    .mclk(mclk), .rst(rst), .rd(rd), .rdata(rdata),
    .reverse_support_pin(reverse_support_pin),
    .input_overvoltage(input_overvoltage),
    .input_overcurrent(input_overcurrent), .overload_pct(overload_pct),
    .min_voltage_support(min_voltage_support),
    .processor_hot_alert_n(processor_hot_alert_n),
    .pass_through(pass_through), .converter_off(converter_off),
    .ship_discharge(ship_discharge), .battery_switch_on(battery_switch_on)
);

// *** tb/cmh_alert_rx.sv ***
`timescale 1ns/1ps
module cmh_alert_rx (
    input  wire logic mclk,
    input  wire logic processor_hot_alert_n,
    output int        low_width
);
    int run_r = 0;
    // processor side only learns a width once the line is released
    always @(posedge mclk) begin
        if (!processor_hot_alert_n) run_r <= run_r + 1;
        else if (run_r != 0) begin
            low_width <= run_r;
            run_r <= 0;
        end
    end
endmodule : cmh_alert_rx

// *** tb/test_charger_mode_hot_alert_ctrl.sv ***
`timescale 1ns/1ps
module test_charger_mode_hot_alert_ctrl;
    logic        mclk = 1'h0;
    logic        rst = 1'h1;
    logic [7:0]  addr = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'h0;
    logic        rd = 1'h0;
    logic [2:0]  pk = 3'h0;
    logic        pin = 1'h0, hiz = 1'h1, ovv = 1'h0, occ = 1'h0;
    logic [7:0]  ev = 8'h00;
    logic [7:0]  olim = 8'hC3;
    logic [15:0] rdata;
    logic [8:0]  pct;
    logic        ovl, sup, hot_n, pass, hs, coff, cgood, ship, bsw;
    int          rx_w;
    int          errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    always #50 mclk = ~mclk;
    cmh_ctrl #(.SHIP_CYCLES(20), .MS_CYCLES(4)) uut (
        .mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .batt_discharging(pk[2]), .sys_droop(1'h0),
        .at_dc_limit(pk[1]), .load_high(pk[0]), .reverse_support_pin(pin),
        .limit_highz_pin(hiz), .battery_present_pin(!ev[5]),
        .adapter_present_flag(!ev[4]), .comparator_output(!ev[6]),
        .input_overvoltage(ovv), .system_overvoltage(1'h0),
        .thermal_shutdown(ovv), .battery_overcurrent(occ),
        .input_overcurrent(occ), .peak_over_limit(ev[0]),
        .avg_over_limit(ev[1]), .discharge_over_limit(ev[2]),
        .sys_below_alert_level(ev[3]), .input_voltage_low(ev[7]),
        .optimizer_limit(olim), .overload_active(ovl), .overload_pct(pct),
        .min_voltage_support(sup), .processor_hot_alert_n(hot_n),
        .pass_through(pass), .high_sides_on(hs), .converter_off(coff),
        .charge_good_output(cgood), .ship_discharge(ship),
        .battery_switch_on(bsw)
    );
    cmh_alert_rx u_rx (.mclk(mclk), .processor_hot_alert_n(hot_n),
        .low_width(rx_w));
    task automatic complete_run();
        if (errors == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'h1;
        @(posedge mclk);
        wr <= 1'h0;
    endtask : wr_reg
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'h1;
        @(posedge mclk);
        rd <= 1'h0;
        #1 chk(rdata, exp);
    endtask : chk_rd
    task automatic pulse(input logic [7:0] v);
        @(posedge mclk) ev <= v;
        @(posedge mclk) ev <= 8'h00;
    endtask : pulse
    task automatic t_regs();
        chk_rd(cmh_pkg::ADDR_MODE, 16'h0090);
        chk_rd(8'hFC, 16'h0000);
        chk({hot_n, cgood, 5'h00, pct}, 16'hC06E);
        wr_reg(cmh_pkg::ADDR_LIMITS, 16'h005A);
        chk_rd(cmh_pkg::ADDR_LIMITS, 16'h5A5A);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0050);
        chk_rd(cmh_pkg::ADDR_LIMITS, 16'hC35A);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0090);
    endtask : t_regs
    task automatic t_peak();
        logic [4:0] c[6] = '{5'h00, 5'h01, 5'h18, 5'h19, 5'h1D, 5'h1F};
        logic [8:0] p[6] = '{9'h06E, 9'h073, 9'h0E6, 9'h0FA, 9'h1C2, 9'h1C2};
        logic [7:0] cfg[3] = '{8'h00, 8'h11, 8'h51};
        int exp[3] = '{0, 16, 32};
        int n;
        for (int i = 0; i < 6; i++) begin
            wr_reg(cmh_pkg::ADDR_OVLD_PCT, {8'h00, c[i], 3'h0});
            cyc(2);
            chk({7'h00, pct}, {7'h00, p[i]});
        end
        @(posedge mclk) pk <= 3'h7;
        for (int i = 0; i < 3; i++) begin
            wr_reg(cmh_pkg::ADDR_PEAK, {8'h00, cfg[i]});
            cyc(20);
            n = 0;
            repeat (32) begin
                @(posedge mclk);
                #1 n += (ovl === 1'h1);
            end
            chk(16'(n), 16'(exp[i]));
        end
        @(posedge mclk) pk <= 3'h0;
    endtask : t_peak
    task automatic t_support();
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0080);
        @(posedge mclk) pin <= 1'h1;
        cyc(4);
        chk(sup, 1'h1);
        @(posedge mclk) pin <= 1'h0;
        cyc(4);
        chk(sup, 1'h0);
        cyc(120);
        chk(hot_n, 1'h0);
        chk_rd(cmh_pkg::ADDR_HOT_STAT, 16'h0100);
        chk_rd(cmh_pkg::ADDR_HOT_STAT, 16'h0000);
        wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0010);
        cyc(3);
        chk(hot_n, 1'h1);
        @(posedge mclk) pin <= 1'h1;
        cyc(4);
        chk(sup, 1'h1);
        @(posedge mclk) ovv <= 1'h1;
        @(posedge mclk) ovv <= 1'h0;
        cyc(4);
        chk(sup, 1'h0);
        chk_rd(cmh_pkg::ADDR_MODE, 16'h0090);
        chk(hot_n, 1'h0);
        chk_rd(cmh_pkg::ADDR_HOT_STAT, 16'h0100);
        @(posedge mclk) pin <= 1'h0;
        cyc(120);
        wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0000);
    endtask : t_support
    task automatic t_events();
        for (int i = 0; i < 8; i++) begin
            wr_reg(cmh_pkg::ADDR_HOT_EN, 16'(1 << i));
            pulse(8'(1 << i));
            cyc(3);
            chk(hot_n, 1'h0);
            chk_rd(cmh_pkg::ADDR_HOT_STAT, 16'(1 << i));
            cyc(60);
            wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0000);
            cyc(3);
            chk(hot_n, 1'h1);
        end
        wr_reg(cmh_pkg::ADDR_HOT_EN, 16'h0000);
        pulse(8'hFF);
        cyc(3);
        chk(hot_n, 1'h1);
        cyc(60);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0690);
        pulse(8'h40);
        cyc(3);
        chk(hot_n, 1'h0);
        cyc(60);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0090);
        wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0010);
    endtask : t_events
    task automatic t_width();
        wr_reg(cmh_pkg::ADDR_HOT_EN, 16'h0001);
        pulse(8'h01);
        cyc(100);
        chk(16'(rx_w >= 80 && rx_w <= 82), 16'h0001);
        @(posedge mclk) ev <= 8'h01;
        cyc(150);
        @(posedge mclk) ev <= 8'h00;
        cyc(10);
        chk(16'(rx_w >= 150 && rx_w <= 154), 16'h0001);
        wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0040);
        pulse(8'h01);
        cyc(150);
        chk(hot_n, 1'h0);
        wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0040);
        cyc(3);
        chk(hot_n, 1'h1);
        wr_reg(cmh_pkg::ADDR_HOT_CFG, 16'h0010);
    endtask : t_width
    task automatic t_modes();
        int n = 0;
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0092);
        repeat (100) begin
            @(posedge mclk);
            #1 n += (ship === 1'h1);
        end
        chk(16'(n), 16'h0014);
        chk_rd(cmh_pkg::ADDR_MODE, 16'h0090);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0091);
        cyc(3);
        chk({bsw, coff}, 2'h3);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0090);
        cyc(3);
        chk({bsw, coff}, 2'h0);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0091);
        @(posedge mclk) ev <= 8'h20;
        cyc(4);
        chk({bsw, coff}, 2'h0);
        @(posedge mclk) ev <= 8'h00;
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0098);
        pulse(8'h40);
        cyc(4);
        chk({coff, cgood, hs}, 3'h4);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0090);
        cyc(3);
        chk({coff, cgood}, 2'h1);
        wr_reg(cmh_pkg::ADDR_MODE, 16'h0114);
        @(posedge mclk) hiz <= 1'h0;
        cyc(4);
        chk({pass, hs}, 2'h3);
        @(posedge mclk) occ <= 1'h1;
        @(posedge mclk) occ <= 1'h0;
        cyc(4);
        chk({pass, hs}, 2'h0);
        chk_rd(cmh_pkg::ADDR_MODE, 16'h0110);
    endtask : t_modes
    initial begin
        repeat (10) @(posedge mclk);
        rst <= 1'h0;
        t_regs();
        t_peak();
        t_support();
        t_events();
        t_width();
        t_modes();
        complete_run();
    end
    // ceiling well above the roughly eighteen hundred cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
endmodule : test_charger_mode_hot_alert_ctrl
